// >>> rtl/fpuct_core.v
// Purpose: Timing, overlap and response sequencing of a float coprocessor.
// Assumes: Host issues one instruction at a time with head/tail figures.
// Notes: Overlap and adjusted length are kept per acceptance for the host.
// Functional notes
// - Dynamic decimal precision adds 14 cycles.
// - Data register source -5, destination -2 cycles.
// - Store start answers null, repeat and interrupts set.
// - Then transfer primitive, then null without repeat.
// - Each waiting poll returns another repeating null.
// - Plain variant polls 5/3/1/194 per format.
// - Concurrent variant polls 5 integer, 194 packed.
// - Plain variant never overlaps instructions.
// - Concurrent variant accepts next during tail.
// - Register conflict withholds overlap until clear.
// - Register moves have no tail period.
// - Overlap is min of tail and head.
// - Store class head excludes address time.
// - Constant load sources from internal table.
`timescale 1ns/1ps
`include "fpuct_regs.vh"
module fpuct_core (
    input wire core_clk, // System clock, 50 MHz.
    input wire reset, // Synchronous reset, active high.
    input wire concurrent_mode, // High selects the overlapping variant.
    input wire instr_valid, // Host offers an instruction.
    output wire instr_ready, // Device accepts the instruction.
    input wire [15:0] instr_head, // Table head cycles.
    input wire [15:0] instr_tail, // Table tail cycles.
    input wire [15:0] instr_ea_time, // Effective address cycles.
    input wire [2:0] instr_opclass, // Operation class.
    input wire instr_is_store, // Move-to-memory instruction.
    input wire instr_is_regmove, // Fully concurrent register move.
    input wire instr_is_const_load, // Constant-load instruction.
    input wire [6:0] instr_const_index, // Constant table index.
    input wire [2:0] instr_format, // Destination operand format.
    input wire instr_dyn_precision, // Precision from a data register.
    input wire instr_src_dreg, // Source is a host data register.
    input wire instr_dst_dreg, // Destination is a host data register.
    input wire [2:0] instr_src_fp, // float_src_reg number.
    input wire [2:0] instr_dst_fp, // float_dest_reg number.
    input wire resp_read, // Host reads the response window.
    output reg [3:0] resp_prim, // Primitive code.
    output reg repeat_request_bit, // Host must read again.
    output reg interrupts_allowed_bit, // Host may take interrupts while waiting.
    input wire xfer_done, // Host finished the data transfer.
    output reg [15:0] overlap_reg, // Overlap granted to last acceptance.
    output reg [15:0] exec_len_reg, // Adjusted length of last instruction.
    output reg [6:0] const_addr_reg, // Constant table address in use.
    output reg const_sel_reg, // Operand taken from constant table.
    output wire busy // Instruction in progress.
);
    // Store response states; IDLE also serves every non-store instruction.
    // POLL answers repeating nulls until the poll budget is spent, XFER
    // holds the transfer primitive until the host reports the move done,
    // and DONE waits for the host to read the closing null.
    localparam S_IDLE = 2'd0;
    localparam S_POLL = 2'd1;
    localparam S_XFER = 2'd2;
    localparam S_DONE = 2'd3;

    // Sequence state and the destination of the running instruction.
    reg [1:0] st_reg;
    reg [7:0] poll_left_reg;
    reg [2:0] busy_dst_reg;
    reg busy_dst_valid_reg;

    // Combinational figures of the offered instruction.
    reg [15:0] head_eff;
    reg [15:0] head_next;
    reg [15:0] tail_next;
    reg [15:0] len_adj;
    reg [7:0] polls;

    // Phase counter view and handshake terms.
    wire in_head;
    wire in_tail;
    wire [15:0] left;
    wire conflict;
    wire load;

    // Smaller of two cycle counts.
    function [15:0] min16;
        input [15:0] a;
        input [15:0] b;
        begin
            min16 = (a < b) ? a : b;
        end
    endfunction

    // Poll count depends on format alone, not on variant; concurrent variant has no figures
    // for single, double or extended, so those reuse the plain counts.
    // Figures assume the host takes no interrupt while it polls.
    always @* begin
        case (instr_format)
            `FPUCT_FMT_INT: polls = `FPUCT_POLL_INT;
            `FPUCT_FMT_SGL: polls = `FPUCT_POLL_SGLDBL;
            `FPUCT_FMT_DBL: polls = `FPUCT_POLL_SGLDBL;
            `FPUCT_FMT_EXT: polls = `FPUCT_POLL_EXT;
            `FPUCT_FMT_PACKED: polls = `FPUCT_POLL_PACKED;
            default: polls = `FPUCT_POLL_INT;
        endcase
    end

    // Effective head and tail, and adjusted overall length.
    always @* begin
        if (instr_is_store && instr_opclass == `FPUCT_OPCLASS_STORE)
            head_eff = instr_head;
        else
            head_eff = instr_head + instr_ea_time;
        tail_next = instr_is_regmove ? 16'h0000 : instr_tail;
        len_adj = head_eff + tail_next;
        if (instr_dyn_precision && instr_format == `FPUCT_FMT_PACKED)
            len_adj = len_adj + `FPUCT_DYN_PREC_EXTRA;
        if (instr_src_dreg && len_adj > `FPUCT_SRC_DREG_SAVE)
            len_adj = len_adj - `FPUCT_SRC_DREG_SAVE;
        if (instr_dst_dreg && len_adj > `FPUCT_DST_DREG_SAVE)
            len_adj = len_adj - `FPUCT_DST_DREG_SAVE;
        // Adjustments land on the head so the tail stays as tabled; the
        // register-operand savings are skipped when they would wrap.
        head_next = len_adj - tail_next;
    end

    // A follower that touches the running destination must wait, since
    // that register is not final until the running instruction ends.
    assign conflict = busy_dst_valid_reg &&
        (instr_src_fp == busy_dst_reg || instr_dst_fp == busy_dst_reg);
    // Accept when idle; in the concurrent variant also during the tail
    // with no register conflict. Store handshake must be finished.
    assign instr_ready = (st_reg == S_IDLE) &&
        (!(in_head || in_tail) ||
         (concurrent_mode && in_tail && !in_head && !conflict));
    assign load = instr_valid && instr_ready;
    // Busy covers both the phase counter and an unfinished store.
    assign busy = in_head || in_tail || (st_reg != S_IDLE);

    // Head and tail are timed on the shared clock by the phase counter.
    fpuct_phase_counter u_phase (
        .core_clk(core_clk),
        .reset(reset),
        .load(load),
        .head_len(head_next),
        .tail_len(tail_next),
        .in_head(in_head),
        .in_tail(in_tail),
        .left_reg(left)
    );

    // Bookkeeping of accepted instruction, overlap and constant source.
    // Overlap is judged against the tail left at the accepting edge; the
    // rest of that tail is dropped because the newcomer takes the counter.
    always @(posedge core_clk) begin
        if (reset) begin
            overlap_reg <= 16'h0000;
            exec_len_reg <= 16'h0000;
            const_addr_reg <= 7'h00;
            const_sel_reg <= 1'b0;
            busy_dst_reg <= 3'h0;
            busy_dst_valid_reg <= 1'b0;
        end else if (load) begin
            if (in_tail)
                overlap_reg <= min16(left, head_next);
            else
                overlap_reg <= 16'h0000;
            exec_len_reg <= len_adj;
            const_sel_reg <= instr_is_const_load;
            const_addr_reg <= instr_is_const_load ? instr_const_index : 7'h00;
            busy_dst_reg <= instr_dst_fp;
            busy_dst_valid_reg <= !instr_is_store;
        end else if (!(in_head || in_tail)) begin
            busy_dst_valid_reg <= 1'b0;
        end
    end

    // Response sequence for a move to memory.
    // Interrupts-allowed drops with the transfer primitive so the host
    // does not break off in the middle of the data move.
    always @(posedge core_clk) begin
        if (reset) begin
            st_reg <= S_IDLE;
            poll_left_reg <= 8'h00;
            resp_prim <= `FPUCT_PRIM_NULL;
            repeat_request_bit <= 1'b0;
            interrupts_allowed_bit <= 1'b0;
        end else begin
            case (st_reg)
                S_IDLE: begin
                    if (load && instr_is_store) begin
                        st_reg <= S_POLL;
                        poll_left_reg <= polls;
                        resp_prim <= `FPUCT_PRIM_NULL;
                        repeat_request_bit <= 1'b1;
                        interrupts_allowed_bit <= 1'b1;
                    end
                end
                S_POLL: begin
                    // First read plus the extra polls see repeating nulls.
                    if (resp_read) begin
                        if (poll_left_reg == 8'h00) begin
                            st_reg <= S_XFER;
                            resp_prim <= `FPUCT_PRIM_EA_XFER;
                            repeat_request_bit <= 1'b0;
                            interrupts_allowed_bit <= 1'b0;
                        end else begin
                            poll_left_reg <= poll_left_reg - 8'h01;
                        end
                    end
                end
                S_XFER: begin
                    if (xfer_done) begin
                        st_reg <= S_DONE;
                        resp_prim <= `FPUCT_PRIM_NULL;
                        repeat_request_bit <= 1'b0;
                    end
                end
                S_DONE: begin
                    if (resp_read)
                        st_reg <= S_IDLE;
                end
                default: st_reg <= S_IDLE;
            endcase
        end
    end
endmodule // fpuct_core

// >>> rtl/fpuct_regs.vh
// Purpose: Shared constants for the coprocessor timing and overlap block.
// Assumes: One 50 MHz clock, synchronous active-high reset.
// Notes: Response primitive codes and cycle adjustments live here.
`ifndef FPUCT_REGS_VH
`define FPUCT_REGS_VH
`define FPUCT_DYN_PREC_EXTRA 16'h000e
`define FPUCT_SRC_DREG_SAVE 16'h0005
`define FPUCT_DST_DREG_SAVE 16'h0002
`define FPUCT_POLL_INT 8'h05
`define FPUCT_POLL_SGLDBL 8'h03
`define FPUCT_POLL_EXT 8'h01
`define FPUCT_POLL_PACKED 8'hc2
`define FPUCT_PRIM_NULL 4'h0
`define FPUCT_PRIM_EA_XFER 4'h1
`define FPUCT_FMT_INT 3'h0
`define FPUCT_FMT_SGL 3'h1
`define FPUCT_FMT_DBL 3'h2
`define FPUCT_FMT_EXT 3'h3
`define FPUCT_FMT_PACKED 3'h4
`define FPUCT_OPCLASS_STORE 3'h3
`endif

// >>> rtl/fpuct_phase_counter.v
// Purpose: Down counter that tracks head and tail phases of one instruction.
// Assumes: Loaded with head and tail lengths when an instruction starts.
// Notes: The tail phase is where the next instruction may overlap.
`timescale 1ns/1ps
module fpuct_phase_counter (
    input wire core_clk, // System clock.
    input wire reset, // Synchronous reset, active high.
    input wire load, // Start a new instruction.
    input wire [15:0] head_len, // Head cycles to run.
    input wire [15:0] tail_len, // Tail cycles to run.
    output reg in_head, // Head phase active.
    output reg in_tail, // Tail phase active.
    output reg [15:0] left_reg // Cycles left in current phase.
);
    // Tail length is held from the load, because the host may already
    // present the next instruction while this one still runs.
    reg [15:0] tail_hold_reg;

    // Head counts down first, then tail; a zero tail ends at head end.
    always @(posedge core_clk) begin
        if (reset) begin
            in_head <= 1'b0;
            in_tail <= 1'b0;
            left_reg <= 16'h0000;
            tail_hold_reg <= 16'h0000;
        end else if (load) begin
            in_head <= (head_len != 16'h0000);
            in_tail <= (head_len == 16'h0000) && (tail_len != 16'h0000);
            left_reg <= (head_len != 16'h0000) ? head_len : tail_len;
            tail_hold_reg <= tail_len;
        end else if (left_reg > 16'h0001) begin
            left_reg <= left_reg - 16'h0001;
        end else if (in_head && tail_hold_reg != 16'h0000) begin
            in_head <= 1'b0;
            in_tail <= 1'b1;
            left_reg <= tail_hold_reg;
        end else begin
            in_head <= 1'b0;
            in_tail <= 1'b0;
            left_reg <= 16'h0000;
        end
    end
endmodule // fpuct_phase_counter

// >>> dv/fpuct_monitor.sv
// Purpose: Assertion checker on the fpuct_core ports.
// Assumes: One clock, synchronous active-high reset.
// Notes: Bound to every fpuct_core instance.
`timescale 1ns/1ps
`include "fpuct_regs.vh"
module fpuct_monitor (
    input wire core_clk, // Clock.
    input wire reset, // Synchronous reset, active high.
    input wire concurrent_mode, // Variant select.
    input wire busy, // Activity.
    input wire instr_valid, // Offer.
    input wire instr_ready, // Acceptance.
    input wire instr_is_store, // Move to memory.
    input wire instr_is_const_load, // Constant load.
    input wire [6:0] instr_const_index, // Constant index.
    input wire xfer_done, // Transfer finished.
    input wire [3:0] resp_prim, // Primitive code.
    input wire repeat_request_bit, // Read again.
    input wire interrupts_allowed_bit, // Interrupts allowed.
    input wire [15:0] overlap_reg, // Granted overlap.
    input wire [6:0] const_addr_reg, // Constant address.
    input wire const_sel_reg // Constant select.
);
    wire take = instr_valid && instr_ready; // Request taken at this edge.
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (reset);
    // A store opens with a waiting null, and every waiting null allows interrupts.
    sequence store_taken; take && instr_is_store; endsequence
    sequence null_wait;
        resp_prim == `FPUCT_PRIM_NULL && repeat_request_bit && interrupts_allowed_bit;
    endsequence
    plain_refuse_a: assert property (!concurrent_mode && busy |-> !instr_ready)
        else $error("plain variant ready while busy");
    plain_lap_a: assert property (take && !concurrent_mode |=> overlap_reg == 16'h0000)
        else $error("plain variant granted overlap");
    store_start_a: assert property (store_taken |=> null_wait)
        else $error("store did not open with waiting null");
    poll_null_a: assert property (repeat_request_bit |-> null_wait)
        else $error("repeat set outside waiting null");
    ea_flags_a: assert property (resp_prim == `FPUCT_PRIM_EA_XFER |-> !repeat_request_bit)
        else $error("transfer primitive asks repeat");
    xfer_null_a: assert property (resp_prim == `FPUCT_PRIM_EA_XFER && xfer_done |=>
        resp_prim == `FPUCT_PRIM_NULL && !repeat_request_bit) else $error("no final null");
    const_pick_a: assert property (take && instr_is_const_load |=>
        const_sel_reg && const_addr_reg == $past(instr_const_index)) else $error("bad const");
    const_clear_a: assert property (take && !instr_is_const_load |=> !const_sel_reg)
        else $error("const select left set");
endmodule // fpuct_monitor
bind fpuct_core fpuct_monitor mon (.core_clk(core_clk), .reset(reset),
    .concurrent_mode(concurrent_mode), .busy(busy), .instr_valid(instr_valid),
    .instr_ready(instr_ready), .instr_is_store(instr_is_store),
    .instr_is_const_load(instr_is_const_load), .instr_const_index(instr_const_index),
    .xfer_done(xfer_done), .resp_prim(resp_prim), .repeat_request_bit(repeat_request_bit),
    .interrupts_allowed_bit(interrupts_allowed_bit), .overlap_reg(overlap_reg),
    .const_addr_reg(const_addr_reg), .const_sel_reg(const_sel_reg));

// >>> dv/fpuct_host_model.sv
// Purpose: Host side of a store: polls, transfers, takes the final null.
// Assumes: Drives 1 ns after the rising edge.
// Notes: A gap between reads models a slow host.
`timescale 1ns/1ps
`include "fpuct_regs.vh"
module fpuct_host_model (
    input wire core_clk, // Clock.
    input wire [3:0] resp_prim, // Primitive seen.
    input wire repeat_request_bit, // Read again.
    output reg resp_read, // Read strobe.
    output reg xfer_done // Transfer finished.
);
    integer k;
    initial {resp_read, xfer_done} = 2'b00;
    // Read is held high across back-to-back polls so no time step assigns it twice.
    task automatic serve(input integer gap, output integer reads, output integer ok);
        {reads, ok} = 0;
        for (k = 0; k < 4 && !repeat_request_bit; k++) @(posedge core_clk) #1;
        while (repeat_request_bit && reads < 400) begin
            resp_read = 1'b1;
            reads = reads + 1;
            @(posedge core_clk) #1;
            if (gap > 0) begin
                resp_read = 1'b0;
                repeat (gap) @(posedge core_clk) #1;
            end
        end
        resp_read = 1'b0;
        if (resp_prim === `FPUCT_PRIM_EA_XFER) begin
            xfer_done = 1'b1;
            @(posedge core_clk) #1;
            {xfer_done, resp_read} = 2'b01;
            ok = (resp_prim === `FPUCT_PRIM_NULL && repeat_request_bit === 1'b0);
            @(posedge core_clk) #1;
            resp_read = 1'b0;
        end
    endtask
endmodule // fpuct_host_model

// >>> dv/tb_fpuct_core.sv
// Purpose: Self-checking bench for fpuct_core.
// Assumes: 50 MHz clock, reset held 8 cycles.
// Notes: Inputs change 1 ns after the rising edge.
`timescale 1ns/1ps
`include "fpuct_regs.vh"
module tb_fpuct_core;
    reg core_clk = 1'b0, reset = 1'b1, concurrent_mode = 1'b0, instr_valid = 1'b0;
    reg [15:0] instr_head, instr_tail, instr_ea_time;
    reg [2:0] instr_opclass, instr_format, instr_src_fp, instr_dst_fp;
    reg instr_is_store, instr_is_regmove, instr_is_const_load, instr_dyn_precision;
    reg instr_src_dreg, instr_dst_dreg;
    reg [6:0] instr_const_index;
    wire instr_ready, busy, resp_read, xfer_done, repeat_request_bit, ia_bit, const_sel_reg;
    wire [3:0] resp_prim;
    wire [15:0] overlap_reg, exec_len_reg;
    wire [6:0] const_addr_reg;
    integer err_count = 0, n_tests = 0, reads, ok, t0;
    fpuct_core dut (.core_clk(core_clk), .reset(reset), .concurrent_mode(concurrent_mode),
        .instr_valid(instr_valid), .instr_ready(instr_ready), .instr_head(instr_head),
        .instr_tail(instr_tail), .instr_ea_time(instr_ea_time), .instr_opclass(instr_opclass),
        .instr_is_store(instr_is_store), .instr_is_regmove(instr_is_regmove),
        .instr_is_const_load(instr_is_const_load), .instr_const_index(instr_const_index),
        .instr_format(instr_format), .instr_dyn_precision(instr_dyn_precision),
        .instr_src_dreg(instr_src_dreg), .instr_dst_dreg(instr_dst_dreg),
        .instr_src_fp(instr_src_fp), .instr_dst_fp(instr_dst_fp), .resp_read(resp_read),
        .resp_prim(resp_prim), .repeat_request_bit(repeat_request_bit),
        .interrupts_allowed_bit(ia_bit), .xfer_done(xfer_done), .overlap_reg(overlap_reg),
        .exec_len_reg(exec_len_reg), .const_addr_reg(const_addr_reg),
        .const_sel_reg(const_sel_reg), .busy(busy));
    fpuct_host_model host (.core_clk(core_clk), .resp_prim(resp_prim),
        .repeat_request_bit(repeat_request_bit), .resp_read(resp_read), .xfer_done(xfer_done));
    // Free-running clock and a watchdog well beyond the expected run.
    initial forever #10 core_clk = ~core_clk;
    initial begin
        #400000 err_count = err_count + 1;
        report_and_stop;
    end
    task check(input [15:0] got, input [15:0] exp);
        n_tests = n_tests + 1;
        if (got !== exp) begin
            err_count = err_count + 1;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task prep(input [15:0] h, input [15:0] t, input [15:0] e, input [2:0] fmt, input st);
        {instr_head, instr_tail, instr_ea_time, instr_format, instr_is_store} = {h, t, e, fmt, st};
        instr_opclass = st ? `FPUCT_OPCLASS_STORE : 3'h0;
        {instr_is_regmove, instr_is_const_load, instr_dyn_precision} = 3'h0;
        {instr_src_dreg, instr_dst_dreg, instr_src_fp, instr_dst_fp, instr_const_index} = 15'h0;
    endtask
    // Request is held until an edge sees ready high.
    task offer;
        integer n;
        reg got;
        got = 1'b0;
        instr_valid = 1'b1;
        for (n = 0; n < 300 && !got; n++) begin
            #2 got = (instr_ready === 1'b1);
            @(posedge core_clk) #1;
        end
        instr_valid = 1'b0;
        check({15'h0, got}, 16'h0001);
    endtask
    task idle_wait;
        integer n;
        for (n = 0; n < 400 && busy !== 1'b0; n++) @(posedge core_clk) #1;
        check({15'h0, busy}, 16'h0000);
    endtask
    task store_polls(input cm, input [2:0] fmt, input [7:0] polls, input integer gap);
        concurrent_mode = cm;
        prep(16'h0004, 16'h0006, 16'h0003, fmt, 1'b1);
        instr_dyn_precision = (fmt == `FPUCT_FMT_PACKED);
        offer;
        if (fmt == `FPUCT_FMT_PACKED) check(exec_len_reg, 16'h0018);
        host.serve(gap, reads, ok);
        check(reads[15:0], {8'h00, polls} + 16'h0001);
        check(ok[15:0], 16'h0001);
        idle_wait;
    endtask
    task dreg_adjust;
        concurrent_mode = 1'b0;
        prep(16'h000a, 16'h0008, 16'h0006, `FPUCT_FMT_INT, 1'b0);
        instr_src_dreg = 1'b1;
        offer;
        check(exec_len_reg, 16'h0013);
        idle_wait;
        {instr_src_dreg, instr_dst_dreg} = 2'b01;
        offer;
        check(exec_len_reg, 16'h0016);
        idle_wait;
    endtask
    task pair(input cm, input [2:0] bsrc, input [15:0] exp_ovl, input lap);
        concurrent_mode = cm;
        prep(16'h0003, 16'h0014, 16'h0000, `FPUCT_FMT_EXT, 1'b0);
        instr_dst_fp = 3'h1;
        offer;
        t0 = $time;
        @(posedge core_clk) #1;
        prep(16'h0001, 16'h0002, 16'h0001, `FPUCT_FMT_EXT, 1'b0);
        {instr_src_fp, instr_dst_fp} = {bsrc, 3'h3};
        offer;
        check(overlap_reg, exp_ovl);
        check({15'h0, ($time - t0) < 460}, {15'h0, lap});
        idle_wait;
    endtask
    task const_and_move;
        concurrent_mode = 1'b1;
        prep(16'h0003, 16'h0014, 16'h0000, `FPUCT_FMT_EXT, 1'b0);
        {instr_is_const_load, instr_const_index} = 8'hb5;
        offer;
        check({8'h0, const_sel_reg, const_addr_reg}, 16'h00b5);
        idle_wait;
        prep(16'h0003, 16'h0014, 16'h0000, `FPUCT_FMT_EXT, 1'b0);
        instr_is_regmove = 1'b1;
        offer;
        t0 = $time;
        idle_wait;
        check({15'h0, ($time - t0) < 200}, 16'h0001);
    endtask
    task report_and_stop;
        if (err_count == 0 && n_tests > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    // Main sequence after an 8-cycle reset.
    initial begin
        prep(16'h0, 16'h0, 16'h0, 3'h0, 1'b0);
        repeat (8) @(posedge core_clk);
        #1 reset = 1'b0;
        store_polls(1'b0, `FPUCT_FMT_INT, `FPUCT_POLL_INT, 0);
        store_polls(1'b0, `FPUCT_FMT_SGL, `FPUCT_POLL_SGLDBL, 2);
        store_polls(1'b0, `FPUCT_FMT_DBL, `FPUCT_POLL_SGLDBL, 0);
        store_polls(1'b0, `FPUCT_FMT_EXT, `FPUCT_POLL_EXT, 1);
        store_polls(1'b0, `FPUCT_FMT_PACKED, `FPUCT_POLL_PACKED, 0);
        store_polls(1'b1, `FPUCT_FMT_INT, `FPUCT_POLL_INT, 0);
        store_polls(1'b1, `FPUCT_FMT_PACKED, `FPUCT_POLL_PACKED, 2);
        dreg_adjust;
        pair(1'b0, 3'h2, 16'h0000, 1'b0);
        pair(1'b1, 3'h2, 16'h0002, 1'b1);
        pair(1'b1, 3'h1, 16'h0000, 1'b0);
        const_and_move;
        report_and_stop;
    end
endmodule // tb_fpuct_core
